// [logic/ctrl_word_pkg.sv]
// constants for the three-wire control word decoder
// assumes a single 40 MHz clock and synchronous active-high reset
package ctrl_word_pkg;
    // ----------------------------------------
    // word layout
    // ----------------------------------------
    localparam int WORD_LEN = 23;          // type bit plus field positions 1..22
    localparam int CNT_W = 5;
    localparam logic [4:0] WORD_LEN_C = 5'h17;
    localparam int TYPE_POS = 0;           // first bit shifted is type bit
    localparam int CFG_W = 12;
    localparam int POS_ONE = 1;
    localparam int POS_TWO = 2;
    localparam int POS_THREE = 3;
    localparam int POS_FOUR = 4;
    localparam int POS_FIVE = 5;
    localparam int POS_SIX = 6;
    localparam int POS_SEVEN = 7;
    localparam int POS_EIGHT = 8;
    localparam int POS_NINE = 9;
    localparam int POS_TEN = 10;
    localparam int POS_ELEVEN = 11;
    localparam int POS_TWELVE = 12;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam logic [1:0] SYN_RESET = 2'h0;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int EN_WIDTH_NS = 50;       // least load enable width
    localparam int EN_WIDTH_CYC = (EN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------
    // states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_HOLD = 3'b100
    } state_t;
endpackage : ctrl_word_pkg

// [logic/edge_sync.sv]
// two-flop synchroniser with rise and fall detection
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pin
    input wire logic din,
    // synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_r, s2_r, s3_r;
    logic s1_nxt, s2_nxt, s3_nxt;

    // shift chain
    always_comb begin
        s1_nxt = din;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // edges from second and third stages only
    assign level = s2_r;
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule : edge_sync
`default_nettype wire

// [logic/ctrl_word_decode.sv]
// three-wire control word receiver and configuration latches
// assumes MCLK at 40 MHz; bus clock, data, load enable and section enables are async pins
`timescale 1ns/1ps
`default_nettype none
module ctrl_word_decode (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // three-wire bus
    input wire logic BUS_CLK,
    input wire logic BUS_DATA,
    input wire logic LOAD_EN,
    // section enables
    input wire logic RECEIVE_SECTION_ENABLE,
    input wire logic TRANSMIT_SECTION_ENABLE,
    input wire logic SYNTH_SECTION_ENABLE,
    // type-1 controls
    output logic RECEIVE_SECOND_LO_DIV4,
    output logic SYNTH_SECOND_LO_DIV4,
    output logic TRANSMIT_SECOND_LO_DIV4,
    output logic TRANSMIT_IF_DIV2,
    output logic TRANSMIT_MIX_DIV2,
    output logic TRANSMIT_INJ_HIGH,
    output logic RECEIVE_IF1_HIGH_GAIN,
    output logic RECEIVE_IF2_GAIN_18DB,
    output logic RECEIVE_INJ_HIGH,
    output logic TL_CP_HIGH_CURRENT,
    output logic VHF_LO_BUFFER_ENABLE,
    // type-0 controls
    output logic SYNTH_SELECT_UHF,
    output logic SYNTH_SELECT_R_COUNTER,
    // status
    output logic WORD_LOADED,
    output logic LATCH_VALID
);
    import ctrl_word_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic clk_lvl, clk_rise, clk_fall;
    logic data_lvl, data_rise, data_fall;
    logic le_lvl, le_rise, le_fall;
    logic rxe_lvl, txe_lvl, sxe_lvl;

    // every pin passes two flops before any logic reads it; edges come from
    // the second and third stages, so the first stage never feeds decisions
    edge_sync u_clk (.clk(MCLK), .rst(RESET), .din(BUS_CLK), .level(clk_lvl), .rise(clk_rise), .fall(clk_fall));
    edge_sync u_dat (.clk(MCLK), .rst(RESET), .din(BUS_DATA), .level(data_lvl), .rise(data_rise), .fall(data_fall));
    edge_sync u_le (.clk(MCLK), .rst(RESET), .din(LOAD_EN), .level(le_lvl), .rise(le_rise), .fall(le_fall));
    edge_sync u_rxe (.clk(MCLK), .rst(RESET), .din(RECEIVE_SECTION_ENABLE), .level(rxe_lvl), .rise(), .fall());
    edge_sync u_txe (.clk(MCLK), .rst(RESET), .din(TRANSMIT_SECTION_ENABLE), .level(txe_lvl), .rise(), .fall());
    edge_sync u_sxe (.clk(MCLK), .rst(RESET), .din(SYNTH_SECTION_ENABLE), .level(sxe_lvl), .rise(), .fall());

    // any one section enable keeps the latches alive
    logic any_enable;
    assign any_enable = rxe_lvl | txe_lvl | sxe_lvl;

    // ----------------------------------------
    // state
    // ----------------------------------------
    state_t state_r, state_nxt;
    logic [WORD_LEN-1:0] shift_r, shift_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CFG_W-1:0] lo_cfg_r, lo_cfg_nxt;
    logic [1:0] syn_cfg_r, syn_cfg_nxt;
    logic loaded_r, loaded_nxt;
    logic valid_r, valid_nxt;
    logic [WORD_LEN-1:0] word;

    // word as shifted, first bit in at position zero
    always_comb begin
        for (int i = 0; i < WORD_LEN; i++) begin
            word[i] = shift_r[WORD_LEN-1-i];
        end
    end

    // ----------------------------------------
    // shift register and bus state
    // ----------------------------------------
    // a load strobe is honoured only after at least one bit was shifted
    logic take_word;
    assign take_word = (state_r == ST_SHIFT) && le_rise && (cnt_r != '0);

    // bus clock edges are ignored while load enable stands high, so a
    // controller that keeps clocking through the load cannot spoil the word;
    // the counter saturates at the word length and only proves bits arrived
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (clk_rise && !le_lvl) begin
                    // first bit of a new word
                    shift_nxt = {{(WORD_LEN-1){1'b0}}, data_lvl};
                    cnt_nxt = CNT_W'(1);
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (clk_rise && !le_lvl) begin
                    shift_nxt = {shift_r[WORD_LEN-2:0], data_lvl};
                    if (cnt_r != WORD_LEN_C) begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end else if (le_rise) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (le_fall) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // shift state registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_r <= ST_IDLE;
            shift_r <= '0;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ----------------------------------------
    // configuration latches
    // ----------------------------------------
    // two separate latches, so a word of one type never disturbs the other;
    // losing every section enable wipes both, and the wipe wins over a load
    // in the same cycle since nothing may be retained without an enable;
    // the load pulse still reports that the bus completed a transfer
    always_comb begin
        lo_cfg_nxt = lo_cfg_r;
        syn_cfg_nxt = syn_cfg_r;
        loaded_nxt = 1'b0;
        valid_nxt = valid_r;
        // transfer only on load pulse, into latch chosen by type bit
        if (take_word) begin
            loaded_nxt = 1'b1;
            valid_nxt = 1'b1;
            if (word[TYPE_POS]) begin
                lo_cfg_nxt = word[POS_TWELVE:POS_ONE];
            end else begin
                syn_cfg_nxt = word[POS_TWO:POS_ONE];
            end
        end
        // contents lost once every section is disabled
        if (!any_enable) begin
            lo_cfg_nxt = CFG_RESET;
            syn_cfg_nxt = SYN_RESET;
            valid_nxt = 1'b0;
        end
    end

    // latch registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            lo_cfg_r <= CFG_RESET;
            syn_cfg_r <= SYN_RESET;
            loaded_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            lo_cfg_r <= lo_cfg_nxt;
            syn_cfg_r <= syn_cfg_nxt;
            loaded_r <= loaded_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ----------------------------------------
    // outputs, all straight from latches
    // ----------------------------------------
    always_comb begin
        RECEIVE_SECOND_LO_DIV4 = lo_cfg_r[POS_ONE-1];
        SYNTH_SECOND_LO_DIV4 = lo_cfg_r[POS_TWO-1];
        TRANSMIT_SECOND_LO_DIV4 = lo_cfg_r[POS_THREE-1];
        TRANSMIT_IF_DIV2 = lo_cfg_r[POS_FOUR-1];
        TRANSMIT_MIX_DIV2 = lo_cfg_r[POS_FIVE-1];
        TRANSMIT_INJ_HIGH = lo_cfg_r[POS_SIX-1];
        RECEIVE_IF1_HIGH_GAIN = lo_cfg_r[POS_SEVEN-1];
        RECEIVE_IF2_GAIN_18DB = lo_cfg_r[POS_EIGHT-1];
        RECEIVE_INJ_HIGH = lo_cfg_r[POS_NINE-1];
        TL_CP_HIGH_CURRENT = lo_cfg_r[POS_TEN-1];
        VHF_LO_BUFFER_ENABLE = lo_cfg_r[POS_TWELVE-1];
        SYNTH_SELECT_UHF = syn_cfg_r[POS_ONE-1];
        SYNTH_SELECT_R_COUNTER = syn_cfg_r[POS_TWO-1];
        WORD_LOADED = loaded_r;
        LATCH_VALID = valid_r;
    end

    logic unused;
    assign unused = ^{clk_lvl, clk_fall, data_rise, data_fall, word[WORD_LEN-1:POS_TWELVE+1]};
endmodule : ctrl_word_decode
`default_nettype wire

// [bench/ctl_model.sv]
// three-wire bus controller model: shifts a 23-bit word, then pulses load
// assumes 200 ns bus clock period, type bit shifted first
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
    // three-wire bus
    output logic BUS_CLK,
    output logic BUS_DATA,
    output logic LOAD_EN
);
    // bus idle: clock stands low, no load
    initial begin
        BUS_CLK = 1'b0;
        BUS_DATA = 1'b0;
        LOAD_EN = 1'b0;
    end
    // one word: bit 0 is the type bit, bit k is field position k
    task automatic send(input logic [22:0] v);
        for (int i = 0; i < 23; i++) begin
            BUS_DATA = v[i];
            #100 BUS_CLK = 1'b1;
            #100 BUS_CLK = 1'b0;
        end
        BUS_DATA = ~v[22]; // released line shows no stale bit
        #100 LOAD_EN = 1'b1;
        #200 LOAD_EN = 1'b0;
    endtask : send
endmodule : ctl_model
`default_nettype wire

// [bench/ctrl_word_assertions.sv]
// checker for the control word decoder, bound to its ports
// assumes one MCLK domain with sync active-high RESET
`timescale 1ns/1ps
`default_nettype none
module ctrl_word_assertions (
    // clock, reset, bus, enables
    input wire logic MCLK, input wire logic RESET,
    input wire logic BUS_CLK, input wire logic BUS_DATA, input wire logic LOAD_EN,
    input wire logic RECEIVE_SECTION_ENABLE, input wire logic TRANSMIT_SECTION_ENABLE,
    input wire logic SYNTH_SECTION_ENABLE,
    // decoded controls and status
    input wire logic RECEIVE_SECOND_LO_DIV4, input wire logic SYNTH_SECOND_LO_DIV4,
    input wire logic TRANSMIT_SECOND_LO_DIV4, input wire logic TRANSMIT_IF_DIV2,
    input wire logic TRANSMIT_MIX_DIV2, input wire logic TRANSMIT_INJ_HIGH,
    input wire logic RECEIVE_IF1_HIGH_GAIN, input wire logic RECEIVE_IF2_GAIN_18DB,
    input wire logic RECEIVE_INJ_HIGH, input wire logic TL_CP_HIGH_CURRENT,
    input wire logic VHF_LO_BUFFER_ENABLE, input wire logic SYNTH_SELECT_UHF,
    input wire logic SYNTH_SELECT_R_COUNTER, input wire logic WORD_LOADED, input wire logic LATCH_VALID
);
    logic [10:0] cfg;
    logic [1:0] syn;
    logic en_any;
    // type-1 outputs, position twelve first, position eleven left out
    assign cfg = {VHF_LO_BUFFER_ENABLE, TL_CP_HIGH_CURRENT, RECEIVE_INJ_HIGH, RECEIVE_IF2_GAIN_18DB,
        RECEIVE_IF1_HIGH_GAIN, TRANSMIT_INJ_HIGH, TRANSMIT_MIX_DIV2, TRANSMIT_IF_DIV2,
        TRANSMIT_SECOND_LO_DIV4, SYNTH_SECOND_LO_DIV4, RECEIVE_SECOND_LO_DIV4};
    assign syn = {SYNTH_SELECT_R_COUNTER, SYNTH_SELECT_UHF};
    assign en_any = RECEIVE_SECTION_ENABLE | TRANSMIT_SECTION_ENABLE | SYNTH_SECTION_ENABLE;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    // steps: enables all low for a while; load pulse seen a few cycles back
    sequence all_off_s;
        !en_any [*6];
    endsequence
    sequence load_seen_s;
        $past(LOAD_EN, 2) && !$past(LOAD_EN, 7);
    endsequence
    wl_pulse_a: assert property (WORD_LOADED |=> !WORD_LOADED [*8])
        else $error("load pulse too long");
    load_cause_a: assert property (WORD_LOADED |-> load_seen_s)
        else $error("load pulse without load enable");
    idle_load_a: assert property (!LOAD_EN [*8] |-> !WORD_LOADED)
        else $error("load pulse while load enable idle");
    cfg_hold_a: assert property (!$stable(cfg) |-> WORD_LOADED || cfg == 11'h000)
        else $error("type-1 controls moved without load");
    syn_hold_a: assert property (!$stable(syn) |-> WORD_LOADED || syn == 2'h0)
        else $error("synth select moved without load");
    retain_loss_a: assert property (all_off_s |-> cfg == 11'h000 && syn == 2'h0 && !LATCH_VALID)
        else $error("latches kept with enables low");
    valid_set_a: assert property (WORD_LOADED && en_any && $past(en_any, 6) |-> ##[0:1] LATCH_VALID)
        else $error("valid not set after load");
    reset_clear_a: assert property ($fell(RESET) |-> cfg == 11'h000 && syn == 2'h0 && !LATCH_VALID)
        else $error("outputs not cleared by reset");
endmodule : ctrl_word_assertions
bind ctrl_word_decode ctrl_word_assertions chk (.*);
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the control word decoder
// assumes ctl_model drives the bus; checker bound inside uut
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic BUS_CLK, BUS_DATA, LOAD_EN;
    logic RECEIVE_SECTION_ENABLE = 1'b1;
    logic TRANSMIT_SECTION_ENABLE = 1'b0;
    logic SYNTH_SECTION_ENABLE = 1'b0;
    logic RECEIVE_SECOND_LO_DIV4, SYNTH_SECOND_LO_DIV4, TRANSMIT_SECOND_LO_DIV4, TRANSMIT_IF_DIV2;
    logic TRANSMIT_MIX_DIV2, TRANSMIT_INJ_HIGH, RECEIVE_IF1_HIGH_GAIN, RECEIVE_IF2_GAIN_18DB;
    logic RECEIVE_INJ_HIGH, TL_CP_HIGH_CURRENT, VHF_LO_BUFFER_ENABLE, SYNTH_SELECT_UHF;
    logic SYNTH_SELECT_R_COUNTER, WORD_LOADED, LATCH_VALID;
    logic [10:0] exp_cfg = 11'h000;
    logic [1:0] exp_syn = 2'h0;
    logic [22:0] w;
    logic [10:0] got_cfg;
    logic [1:0] got_syn;
    // type-1 controls as seen on the pins, position twelve first, eleven left out
    assign got_cfg = {VHF_LO_BUFFER_ENABLE, TL_CP_HIGH_CURRENT, RECEIVE_INJ_HIGH, RECEIVE_IF2_GAIN_18DB,
        RECEIVE_IF1_HIGH_GAIN, TRANSMIT_INJ_HIGH, TRANSMIT_MIX_DIV2, TRANSMIT_IF_DIV2,
        TRANSMIT_SECOND_LO_DIV4, SYNTH_SECOND_LO_DIV4, RECEIVE_SECOND_LO_DIV4};
    assign got_syn = {SYNTH_SELECT_R_COUNTER, SYNTH_SELECT_UHF};
    int miscompares = 0;
    int n_tests = 0;
    int n_loads = 0;
    ctrl_word_decode uut (.*);
    ctl_model ctl (.*);
    // 40 MHz clock and load pulse counter
    always #12.5 MCLK = ~MCLK;
    always @(posedge MCLK) if (WORD_LOADED === 1'b1) n_loads <= n_loads + 1;
    // expected type-1 controls: position eleven is ignored
    function automatic logic [10:0] exp1(input logic [22:0] v);
        return {v[12], v[10:1]};
    endfunction : exp1
    task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : cyc
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // send one word, then compare both latches and status
    task automatic load(input logic [22:0] v, input bit on);
        int k;
        k = n_loads;
        ctl.send(v);
        cyc(4);
        if (on) chk("loads", 11'(k + 1), 11'(n_loads));
        if (on && v[0]) exp_cfg = exp1(v);
        if (on && !v[0]) exp_syn = v[2:1];
        chk("cfg", exp_cfg, got_cfg);
        chk("syn", 11'(exp_syn), 11'(got_syn));
        chk("valid", 11'(on), 11'(LATCH_VALID));
    endtask : load
    // main sequence: corner words, random words, retention loss
    initial begin
        void'($urandom(88529));
        cyc(20);
        RESET = 1'b0;
        cyc(3);
        chk("rst", 11'h000, got_cfg);
        for (int i = 0; i < 24; i++) begin
            w = 23'($urandom);
            if (i == 0) w = 23'h7FFFFF;
            if (i == 1) w = 23'h001001;
            if (i == 2) w = 23'h000006;
            if (w[0]) w[12] = 1'b1;
            {RECEIVE_SECTION_ENABLE, TRANSMIT_SECTION_ENABLE, SYNTH_SECTION_ENABLE} = 3'(1 + $urandom_range(6));
            load(w, 1'b1);
        end
        {RECEIVE_SECTION_ENABLE, TRANSMIT_SECTION_ENABLE, SYNTH_SECTION_ENABLE} = 3'h0;
        cyc(8);
        exp_cfg = 11'h000;
        exp_syn = 2'h0;
        load(23'h7FFFFF, 1'b0);
        SYNTH_SECTION_ENABLE = 1'b1;
        cyc(8);
        load(23'h001003, 1'b1);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
